// file: hdl/ivu_defines.svh
// channel numbers, sizes and reset values of the interrupt vector unit
`ifndef IVU_DEFINES_SVH
`define IVU_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define IVU_NUM_SRC        32
`define IVU_SRC_W          5
`define IVU_NUM_SLOT       16
`define IVU_SLOT_W         4
`define IVU_ADDR_W         32
`define IVU_NUM_EXT        4
`define IVU_NUM_PWM_MATCH  7

// ----------------------------------------------------------------
// fixed channel positions
// ----------------------------------------------------------------
`define IVU_CH_WATCHDOG    5'h00
`define IVU_CH_SOFTWARE    5'h01
`define IVU_CH_PWM         5'h08
`define IVU_CH_SERIAL      5'h0B
`define IVU_CH_RTC         5'h0D
`define IVU_CH_EXT_BASE    5'h0E

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define IVU_RST_MASK       32'h00000000
`define IVU_RST_STATUS     32'h00000000
`define IVU_RST_VECTOR     32'h00000000

`endif

// file: hdl/ivu_pkg.sv
// types shared by the interrupt vector unit files
package ivu_pkg;

    // ----------------------------------------------------------------
    // one vectored slot as software sets it up
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        en;    // slot in use
        logic [4:0]  src;   // source channel feeding the slot
        logic [31:0] addr;  // handler address of the slot
    } ivu_slot_cfg_t;

    // ----------------------------------------------------------------
    // raw flags of the shared serial channel
    // ----------------------------------------------------------------
    typedef struct packed {
        logic serial_transfer_done_flag;
        logic serial_mode_fault_flag;
        logic sync_port_tx_raw_flag;
        logic sync_port_rx_raw_flag;
        logic sync_port_timeout_raw_flag;
        logic sync_port_overrun_raw_flag;
    } ivu_serial_flags_t;

    // ----------------------------------------------------------------
    // real time clock flags
    // ----------------------------------------------------------------
    typedef struct packed {
        logic clock_increment_flag;
        logic clock_alarm_flag;
    } ivu_rtc_flags_t;

    // ----------------------------------------------------------------
    // state of the vector address selection
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IVU_SEL_IDLE    = 2'b00,
        IVU_SEL_VECTOR  = 2'b01,
        IVU_SEL_DEFAULT = 2'b10
    } ivu_sel_t;

endpackage : ivu_pkg

// file: hdl/ivu_slot.sv
// one vectored slot: matches its source against the active normal requests
`timescale 1ns/1ps
`include "ivu_defines.svh"

module ivu_slot #(
    parameter int NUM_SRC = `IVU_NUM_SRC
) (
    input  wire ivu_pkg::ivu_slot_cfg_t cfg,        // slot setup
    input  wire logic [NUM_SRC-1:0]     normal_act, // active normal sources
    output logic                        hit,        // slot is requesting
    output logic [NUM_SRC-1:0]          claim       // source taken by slot
);

    // ----------------------------------------------------------------
    // source decode
    // ----------------------------------------------------------------
    // one-hot of the source a live slot claims
    always_comb
    begin
        claim = '0;
        if (cfg.en && (int'(cfg.src) < NUM_SRC))
        begin
            claim[cfg.src] = 1'b1;
        end
    end

    // slot requests when its claimed source is active
    assign hit = |(claim & normal_act);

endmodule : ivu_slot

// file: hdl/interrupt_vector_unit.sv
// interrupt vector unit: sorts sources into fast, vectored and default classes
//
// What this block does
// - software assigns each source fast, vectored, or default
// - fast class outranks all normal requests
// - all active fast sources OR into fast output
// - status word shows requesting fast sources
// - sixteen slots, slot 0 highest, 15 lowest
// - default sources rank below slots and fast
// - vectored and default requests OR into normal output
// - vector address: best slot, else default address
// - status word shows active normal sources
// - one request line per channel; channels 8, 11 and 13 OR several flag inputs
// - channel 0 watchdog; channel 1 software only
// - channels 14 to 17 carry external pins
// - channel 13 carries both clock flags
// - channel 11 carries serial and sync port flags
// - channel 8 carries all seven match flags
`timescale 1ns/1ps
`include "ivu_defines.svh"

module interrupt_vector_unit #(
    parameter int NUM_SRC  = `IVU_NUM_SRC,
    parameter int NUM_SLOT = `IVU_NUM_SLOT
) (
    input  wire logic                                  mclk,               // system clock
    input  wire logic                                  rst,                // async reset, high
    input  wire logic                                  ce,                 // clock enable
    input  wire logic                                  watchdog_request,   // watchdog line
    input  wire logic                                  soft_request,       // software raise
    input  wire logic [`IVU_NUM_PWM_MATCH-1:0]         pwm_match_flags,    // match flags, first at 0
    input  wire ivu_pkg::ivu_serial_flags_t            serial_flags,       // shared serial flags
    input  wire ivu_pkg::ivu_rtc_flags_t               rtc_flags,          // clock flags
    input  wire logic [`IVU_NUM_EXT-1:0]               external_request,   // external pins
    input  wire logic [NUM_SRC-1:0]                    periph_request,     // other peripheral lines
    input  wire logic [NUM_SRC-1:0]                    enable_set,         // mask bits to set
    input  wire logic [NUM_SRC-1:0]                    enable_clr,         // mask bits to clear
    input  wire logic [NUM_SRC-1:0]                    fast_select,        // 1 = fast class
    input  wire ivu_pkg::ivu_slot_cfg_t [NUM_SLOT-1:0] slot_cfg,           // vectored slots
    input  wire logic [`IVU_ADDR_W-1:0]                default_address,    // shared handler
    output logic                                       fast_request_out,   // fast request
    output logic                                       normal_request_out, // normal request
    output logic [`IVU_ADDR_W-1:0]                     vector_address,     // handler to run
    output logic [NUM_SRC-1:0]                         fast_status,        // fast sources active
    output logic [NUM_SRC-1:0]                         normal_status,      // normal sources active
    output logic [NUM_SRC-1:0]                         enable_mask,        // present mask
    output logic [NUM_SRC-1:0]                         raw_status          // unmasked lines
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [`IVU_NUM_EXT-1:0]    ext_meta_ff;
    logic [`IVU_NUM_EXT-1:0]    ext_sync_ff;
    logic [`IVU_NUM_EXT-1:0]    nxt_ext_meta;
    logic [`IVU_NUM_EXT-1:0]    nxt_ext_sync;
    logic [NUM_SRC-1:0]         mask_ff;
    logic [NUM_SRC-1:0]         nxt_mask;
    logic [NUM_SRC-1:0]         src_raw;
    logic [NUM_SRC-1:0]         src_act;
    logic [NUM_SRC-1:0]         fast_act;
    logic [NUM_SRC-1:0]         normal_act;
    logic [NUM_SLOT-1:0]        slot_hit;
    logic [NUM_SRC-1:0]         slot_claim [NUM_SLOT];
    logic [NUM_SRC-1:0]         vect_src;
    logic [NUM_SRC-1:0]         dflt_act;
    logic                       any_vect;
    logic [`IVU_SLOT_W-1:0]     best_slot;
    ivu_pkg::ivu_sel_t          sel_ff;
    ivu_pkg::ivu_sel_t          nxt_sel;
    logic [`IVU_ADDR_W-1:0]     vector_ff;
    logic [`IVU_ADDR_W-1:0]     nxt_vector;
    logic [NUM_SRC-1:0]         fast_status_ff;
    logic [NUM_SRC-1:0]         nxt_fast_status;
    logic [NUM_SRC-1:0]         normal_status_ff;
    logic [NUM_SRC-1:0]         nxt_normal_status;
    logic [NUM_SRC-1:0]         raw_status_ff;
    logic [NUM_SRC-1:0]         nxt_raw_status;
    logic                       fast_req_ff;
    logic                       nxt_fast_req;
    logic                       normal_req_ff;
    logic                       nxt_normal_req;

    // ----------------------------------------------------------------
    // external pin synchroniser
    // ----------------------------------------------------------------
    // pins come from outside the clock domain, two stages before use
    always_comb
    begin
        nxt_ext_meta = ext_meta_ff;
        nxt_ext_sync = ext_sync_ff;
        if (ce)
        begin
            nxt_ext_meta = external_request;
            nxt_ext_sync = ext_meta_ff;
        end
    end

    // synchroniser registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ext_meta_ff <= 4'h0;
            ext_sync_ff <= 4'h0;
        end
        else
        begin
            ext_meta_ff <= nxt_ext_meta;
            ext_sync_ff <= nxt_ext_sync;
        end
    end

    // ----------------------------------------------------------------
    // channel map
    // ----------------------------------------------------------------
    // one line per channel; fixed channels override the generic lines
    always_comb
    begin
        src_raw = periph_request;
        src_raw[`IVU_CH_WATCHDOG] = watchdog_request;
        src_raw[`IVU_CH_SOFTWARE] = soft_request;
        src_raw[`IVU_CH_PWM] = |pwm_match_flags;
        src_raw[`IVU_CH_SERIAL] = |serial_flags;
        src_raw[`IVU_CH_RTC] = rtc_flags.clock_increment_flag
                               | rtc_flags.clock_alarm_flag;
        for (int i = 0; i < `IVU_NUM_EXT; i++)
        begin
            src_raw[int'(`IVU_CH_EXT_BASE) + i] = ext_sync_ff[i];
        end
    end

    // ----------------------------------------------------------------
    // enable mask
    // ----------------------------------------------------------------
    // set wins over clear when both hit the same bit
    always_comb
    begin
        nxt_mask = mask_ff;
        if (ce)
        begin
            nxt_mask = (mask_ff & ~enable_clr) | enable_set;
        end
    end

    // mask register, everything off after reset
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mask_ff <= `IVU_RST_MASK;
        end
        else
        begin
            mask_ff <= nxt_mask;
        end
    end

    // ----------------------------------------------------------------
    // classification
    // ----------------------------------------------------------------
    // masked sources split by the live class selection
    assign src_act    = src_raw & mask_ff;
    assign fast_act   = src_act & fast_select;
    assign normal_act = src_act & ~fast_select;

    // one slot per vectored position
    for (genvar s = 0; s < NUM_SLOT; s++)
    begin : g_slot
        ivu_slot #(
            .NUM_SRC    (NUM_SRC)
        ) u_slot (
            .cfg        (slot_cfg[s]),
            .normal_act (normal_act),
            .hit        (slot_hit[s]),
            .claim      (slot_claim[s])
        );
    end

    // sources claimed by a slot are vectored, the rest default
    always_comb
    begin
        vect_src = '0;
        for (int s = 0; s < NUM_SLOT; s++)
        begin
            vect_src = vect_src | slot_claim[s];
        end
        dflt_act = normal_act & ~vect_src;
    end

    // ----------------------------------------------------------------
    // slot priority
    // ----------------------------------------------------------------
    // lowest numbered requesting slot wins
    always_comb
    begin
        any_vect  = 1'b0;
        best_slot = 4'h0;
        for (int s = NUM_SLOT - 1; s >= 0; s--)
        begin
            if (slot_hit[s])
            begin
                any_vect  = 1'b1;
                best_slot = 4'(s);
            end
        end
    end

    // ----------------------------------------------------------------
    // vector address selection
    // ----------------------------------------------------------------
    // vectored slot ahead of default sources
    always_comb
    begin
        nxt_sel    = sel_ff;
        nxt_vector = vector_ff;
        if (ce)
        begin
            case (sel_ff)
                ivu_pkg::IVU_SEL_IDLE,
                ivu_pkg::IVU_SEL_VECTOR,
                ivu_pkg::IVU_SEL_DEFAULT:
                begin
                    if (any_vect)
                    begin
                        nxt_sel    = ivu_pkg::IVU_SEL_VECTOR;
                        nxt_vector = slot_cfg[best_slot].addr;
                    end
                    else if (|dflt_act)
                    begin
                        nxt_sel    = ivu_pkg::IVU_SEL_DEFAULT;
                        nxt_vector = default_address;
                    end
                    else
                    begin
                        nxt_sel    = ivu_pkg::IVU_SEL_IDLE;
                        nxt_vector = default_address;
                    end
                end
                default:
                begin
                    nxt_sel    = ivu_pkg::IVU_SEL_IDLE;
                    nxt_vector = default_address;
                end
            endcase
        end
    end

    // selection registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sel_ff    <= ivu_pkg::IVU_SEL_IDLE;
            vector_ff <= `IVU_RST_VECTOR;
        end
        else
        begin
            sel_ff    <= nxt_sel;
            vector_ff <= nxt_vector;
        end
    end

    // ----------------------------------------------------------------
    // status words and processor requests
    // ----------------------------------------------------------------
    // fast and normal requests computed side by side
    always_comb
    begin
        nxt_fast_status   = fast_status_ff;
        nxt_normal_status = normal_status_ff;
        nxt_raw_status    = raw_status_ff;
        nxt_fast_req      = fast_req_ff;
        nxt_normal_req    = normal_req_ff;
        if (ce)
        begin
            nxt_fast_status   = fast_act;
            nxt_normal_status = normal_act;
            nxt_raw_status    = src_raw;
            nxt_fast_req      = |fast_act;
            nxt_normal_req    = any_vect | (|dflt_act);
        end
    end

    // status and request registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fast_status_ff   <= `IVU_RST_STATUS;
            normal_status_ff <= `IVU_RST_STATUS;
            raw_status_ff    <= `IVU_RST_STATUS;
            fast_req_ff      <= 1'b0;
            normal_req_ff    <= 1'b0;
        end
        else
        begin
            fast_status_ff   <= nxt_fast_status;
            normal_status_ff <= nxt_normal_status;
            raw_status_ff    <= nxt_raw_status;
            fast_req_ff      <= nxt_fast_req;
            normal_req_ff    <= nxt_normal_req;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // all outputs straight from registers
    assign fast_request_out   = fast_req_ff;
    assign normal_request_out = normal_req_ff;
    assign vector_address     = vector_ff;
    assign fast_status        = fast_status_ff;
    assign normal_status      = normal_status_ff;
    assign enable_mask        = mask_ff;
    assign raw_status         = raw_status_ff;

endmodule : interrupt_vector_unit

// file: bench/ivu_core_model.sv
// behavioural core that takes fast and normal requests
`timescale 1ns/1ps

module ivu_core_model (
    input  wire logic        mclk,        // system clock
    input  wire logic        rst,         // async reset, high
    input  wire logic        fast_line,   // fast request in
    input  wire logic        normal_line, // normal request in
    input  wire logic [31:0] handler_in,  // vector address in
    output logic [1:0]       kind_ff,     // 2 fast, 1 normal, 0 none
    output logic [31:0]      addr_ff      // handler fetched
);
    logic [1:0]  nxt_kind;
    logic [31:0] nxt_addr;

    // fast entry outranks normal entry
    always_comb
    begin
        nxt_kind = fast_line ? 2'h2 : {1'b0, normal_line};
        nxt_addr = normal_line ? handler_in : addr_ff;
    end

    // register what the core took
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            kind_ff <= 2'h0;
            addr_ff <= 32'h00000000;
        end
        else
        begin
            kind_ff <= nxt_kind;
            addr_ff <= nxt_addr;
        end
    end
endmodule : ivu_core_model

// file: bench/ivu_properties.sv
// port relations of the interrupt vector unit
`timescale 1ns/1ps
`include "ivu_defines.svh"

module ivu_properties #(
    parameter int NUM_SRC = `IVU_NUM_SRC
) (
    input wire logic               mclk,               // clock
    input wire logic               rst,                // reset
    input wire logic               ce,                 // enable
    input wire logic               watchdog_request,   // channel 0
    input wire logic [6:0]         pwm_match_flags,    // channel 8
    input wire logic [NUM_SRC-1:0] enable_set,         // mask set
    input wire logic [NUM_SRC-1:0] enable_clr,         // mask clear
    input wire logic [NUM_SRC-1:0] fast_select,        // class
    input wire logic [31:0]        default_address,    // shared handler
    input wire logic               fast_request_out,   // fast out
    input wire logic               normal_request_out, // normal out
    input wire logic [31:0]        vector_address,     // handler out
    input wire logic [NUM_SRC-1:0] fast_status,        // fast active
    input wire logic [NUM_SRC-1:0] normal_status,      // normal active
    input wire logic [NUM_SRC-1:0] enable_mask,        // mask
    input wire logic [NUM_SRC-1:0] raw_status          // raw lines
);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    fast_or_a: assert property (fast_request_out == (|fast_status))
        else $error("fast request not OR of fast status");
    normal_or_a: assert property (normal_request_out == (|normal_status))
        else $error("normal request not OR of normal status");
    fast_class_a: assert property (ce |=> fast_status ==
        (raw_status & $past(enable_mask) & $past(fast_select)))
        else $error("fast status wrong");
    normal_class_a: assert property (ce |=> normal_status ==
        (raw_status & $past(enable_mask) & ~$past(fast_select)))
        else $error("normal status wrong");
    mask_update_a: assert property (ce |=> enable_mask ==
        (($past(enable_mask) & ~$past(enable_clr)) | $past(enable_set)))
        else $error("mask update wrong");
    freeze_hold_a: assert property (!ce |=> $stable(enable_mask) && $stable(raw_status))
        else $error("outputs moved with clock enable low");
    raw_map_a: assert property (ce |=> raw_status[0] == $past(watchdog_request)
        && raw_status[8] == (|$past(pwm_match_flags)))
        else $error("raw channel map wrong");
    // the edge that released reset still loaded the reset vector, so skip it
    default_vector_a: assert property ((ce && !rst) |=> (normal_status != '0)
        || (vector_address == $past(default_address)))
        else $error("idle vector not default address");
endmodule : ivu_properties

bind interrupt_vector_unit ivu_properties #(.NUM_SRC(NUM_SRC)) i_ivu_properties (
    .mclk(mclk), .rst(rst), .ce(ce), .watchdog_request(watchdog_request),
    .pwm_match_flags(pwm_match_flags), .enable_set(enable_set), .enable_clr(enable_clr),
    .fast_select(fast_select), .default_address(default_address),
    .fast_request_out(fast_request_out), .normal_request_out(normal_request_out),
    .vector_address(vector_address), .fast_status(fast_status), .normal_status(normal_status),
    .enable_mask(enable_mask), .raw_status(raw_status)
);

// file: bench/testbench.sv
// self-checking bench of the interrupt vector unit
`timescale 1ns/1ps

module testbench;
    logic                               mclk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic                               wd = 1'b0, sw = 1'b0;
    logic [6:0]                         pwm = 7'h00;
    ivu_pkg::ivu_serial_flags_t         ser = '0;
    ivu_pkg::ivu_rtc_flags_t            rtc = '0;
    logic [3:0]                         ext = 4'h0;
    logic [31:0]                        per = 32'h0, eset = 32'h0, eclr = 32'h0, fsel = 32'h0;
    ivu_pkg::ivu_slot_cfg_t [15:0]      slots = '0;
    logic [31:0]                        dflt = 32'h00000F00;
    logic                               fq, nq;
    logic [31:0]                        vec, fst, nst, msk, raw, core_addr;
    logic [1:0]                         core_kind;
    int                                 num_errors = 0, comparisons = 0;
    int                                 src [16] = '{2, 3, 4, 5, 6, 7, 9, 10, 12, 18, 19, 20, 21, 22, 23, 24};

    // clock
    always #25 mclk = ~mclk;

    interrupt_vector_unit i_interrupt_vector_unit (
        .mclk(mclk), .rst(rst), .ce(ce), .watchdog_request(wd), .soft_request(sw),
        .pwm_match_flags(pwm), .serial_flags(ser), .rtc_flags(rtc), .external_request(ext),
        .periph_request(per), .enable_set(eset), .enable_clr(eclr), .fast_select(fsel),
        .slot_cfg(slots), .default_address(dflt), .fast_request_out(fq), .normal_request_out(nq),
        .vector_address(vec), .fast_status(fst), .normal_status(nst), .enable_mask(msk),
        .raw_status(raw));
    ivu_core_model i_ivu_core_model (.mclk(mclk), .rst(rst), .fast_line(fq), .normal_line(nq),
        .handler_in(vec), .kind_ff(core_kind), .addr_ff(core_addr));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    task automatic close_out;
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    // drive single channel sources and compare the raw word
    task automatic raw_case(input logic [17:0] v, input int n, input logic [31:0] exp);
        @(posedge mclk);
        {wd, sw, pwm, ser} <= v[17:3];
        rtc <= v[2:1];
        ext <= {3'h0, v[0]};
        settle(n);
        check("raw", raw, exp);
    endtask : raw_case

    task automatic s_mask;
        @(posedge mclk);
        eset <= 32'hFFFFFFFF;
        eclr <= 32'h0000000F;
        settle(1);
        check("mask", msk, 32'hFFFFFFFF);
        @(posedge mclk);
        eset <= 32'h0;
        eclr <= 32'h00000003;
        wd <= 1'b1;
        settle(2);
        check("mask", msk, 32'hFFFFFFFC);
        check("normal_q", 32'(nq), 32'h0);
        @(posedge mclk);
        eclr <= 32'h0;
        eset <= 32'hFFFFFFFF;
        wd <= 1'b0;
        settle(1);
    endtask : s_mask

    task automatic s_fast;
        @(posedge mclk);
        fsel <= 32'h00000021;
        wd <= 1'b1;
        per <= 32'h02000020;
        settle(1);
        check("fast_st", fst, 32'h00000021);
        check("fast_q", 32'(fq), 32'h1);
        check("normal_st", nst, 32'h02000000);
        settle(1);
        check("core_kind", 32'(core_kind), 32'h2);
        @(posedge mclk);
        fsel <= 32'h0;
        settle(1);
        check("fast_q", 32'(fq), 32'h0);
        check("normal_st", nst, 32'h02000021);
        @(posedge mclk);
        wd <= 1'b0;
    endtask : s_fast

    task automatic s_slots;
        logic [31:0] act;
        act = 32'h02000000;
        @(posedge mclk);
        for (int k = 0; k < 16; k++)
            slots[k] <= {1'b1, 5'(src[k]), 32'h00001000 + 32'(k) * 32'h10};
        for (int k = 15; k >= 0; k--)
        begin
            act[src[k]] = 1'b1;
            @(posedge mclk);
            per <= act;
            settle(1);
            check("vector", vec, 32'h00001000 + 32'(k) * 32'h10);
        end
        @(posedge mclk);
        fsel <= 32'h00000004;
        settle(1);
        check("vector", vec, 32'h00001010);
        check("fast_q", 32'(fq), 32'h1);
        @(posedge mclk);
        fsel <= 32'h0;
        per <= 32'h02000000;
        settle(1);
        check("vector", vec, dflt);
        check("normal_st", nst, 32'h02000000);
        check("normal_q", 32'(nq), 32'h1);
        settle(1);
        check("core_addr", core_addr, dflt);
    endtask : s_slots

    task automatic s_channels;
        @(posedge mclk);
        per <= 32'h0003E903;
        raw_case(18'h20000, 1, 32'h00000001);
        raw_case(18'h10000, 1, 32'h00000002);
        for (int i = 0; i < 7; i++)
            raw_case(18'h00200 << i, 1, 32'h00000100);
        for (int i = 0; i < 6; i++)
            raw_case(18'h00008 << i, 1, 32'h00000800);
        for (int i = 0; i < 2; i++)
            raw_case(18'h00002 << i, 1, 32'h00002000);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            ext <= 4'h1 << i;
            rtc <= '0;
            settle(3);
            check("raw", raw, 32'h00004000 << i);
        end
        raw_case(18'h00000, 3, 32'h0);
    endtask : s_channels

    task automatic s_freeze;
        @(posedge mclk);
        ce <= 1'b0;
        per <= 32'h02000000;
        eclr <= 32'hFFFFFFFF;
        eset <= 32'h0;
        settle(3);
        check("mask", msk, 32'hFFFFFFFF);
        @(posedge mclk);
        ce <= 1'b1;
        settle(2);
        check("mask", msk, 32'h0);
        check("normal_q", 32'(nq), 32'h0);
    endtask : s_freeze

    // main sequence
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        settle(2);
        check("mask", msk, 32'h0);
        check("vector", vec, dflt);
        s_mask();
        s_fast();
        s_slots();
        s_channels();
        s_freeze();
        close_out();
    end

    // watchdog against a hang
    initial
    begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        close_out();
    end
endmodule : testbench
